/* rtl/rbc_clock_calendar.sv */
// Top of the BCD clock and calendar with its nibble-wide bus.
// Overview of operation
// - Address strobe high latches the nibble address.
// - Addresses 0 to C pick the thirteen digits.
// - Digits count in BCD within their ranges.
// - Hours-tens bit 3 picks 24 or 12 hour.
// - Hours-tens bit 2 shows afternoon.
// - Writing bit 3 high clears the afternoon bit.
// - Day-tens bits 2 and 3 select leap years.
// - Select codes 0 to 3 give year-mod-4 remainder 0, 3, 2, 1.
// - February length follows leap rule automatically.
// - Address D with write clears divider top, busy.
// - Address E or F read returns reference taps.
// - Missing bits read zero, writes dropped.
// - Format and leap bits read and write.
// - Seconds come from the divided crystal base.
// - Both chip selects high enable all bus-side inputs.
// - Writes load for as long as strobe high.
// - Halt input stops counting; reads always valid.
`timescale 1ns/100ps
module rbc_clock_calendar (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       chip_select_a,
   input  wire logic       chip_select_b,
   input  wire logic       addrStrobe,
   input  wire logic       writeStrobe,
   input  wire logic       readStrobe,
   input  wire logic       countHalt,
   input  wire logic       testPulse,
   input  wire logic       timeBaseIn,
   input  wire logic [3:0] nibble_busIn,
   output logic      [3:0] nibble_busOut,
   output logic      [3:0] nibble_busOe,
   output logic            busyNOut,
   output logic            busyNOe
);
   // Synchronised pin levels and rise pulses.
   logic [7:0] ctlLevel;     // Control pins after filtering.
   logic [7:0] ctlRise;      // Rising edges of the control pins.
   logic [3:0] busLevel;     // Nibble bus after filtering.
   logic       csOk;         // Both chip selects high.
   logic       addrLoad;     // Address latch transparent.
   logic       wrActive;     // Write strobe active and selected.
   logic       rdActive;     // Read strobe active and selected.
   logic       haltActive;   // Counting stopped.
   logic       testStep;     // Manual count pulse.
   logic       divClear;     // Partial divider reset request.
   logic [14:0] divCount;    // Divider stage values.
   logic       secTick;      // One-second pulse from the divider.
   logic       countTick;    // Tick that advances the calendar.

   // Latched address.
   logic [3:0] addrReg;

   // Time digits; widths follow each digit's legal range.
   logic [3:0] secUReg;
   logic [2:0] secTReg;
   logic [3:0] minUReg;
   logic [2:0] minTReg;
   logic [3:0] hrUReg;
   logic [1:0] hrTReg;
   logic       fmt24Reg;     // 1 selects 24-hour counting.
   logic       pmReg;        // 1 marks the afternoon.
   logic [2:0] wdayReg;
   logic [3:0] dayUReg;
   logic [1:0] dayTReg;
   logic [1:0] leapSelReg;   // Leap select as {bit3, bit2}.
   logic [3:0] monUReg;
   logic       monTReg;
   logic [3:0] yrUReg;
   logic [3:0] yrTReg;

   // Next values from the counting cascade.
   logic [3:0] secUNext;
   logic [2:0] secTNext;
   logic [3:0] minUNext;
   logic [2:0] minTNext;
   logic [3:0] hrUNext;
   logic [1:0] hrTNext;
   logic       pmNext;
   logic [2:0] wdayNext;
   logic [3:0] dayUNext;
   logic [1:0] dayTNext;
   logic [3:0] monUNext;
   logic       monTNext;
   logic [3:0] yrUNext;
   logic [3:0] yrTNext;

   // Calendar helpers.
   logic       secWrap;      // Seconds pass 59.
   logic       minWrap;      // Minutes pass 59 too.
   logic       dayAdvance;   // Midnight crossed.
   logic       monthEnd;     // Today is the month's last day.
   logic       isLeap;       // Current year is a leap year.
   logic [1:0] yearMod4;     // Year modulo four.
   logic [1:0] leapRem;      // Remainder that marks a leap year.
   logic [5:0] lastDay;      // Last day of the month in BCD.
   logic [3:0] readData;     // Data selected for a read.

   // Control pins cross into the clock domain through three flops.
   rbc_pin_sync #(
      .W (8)
   ) u_ctlSync (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .pinIn    ({timeBaseIn, testPulse, countHalt, readStrobe,
                  writeStrobe, addrStrobe, chip_select_b, chip_select_a}),
      .pinLevel (ctlLevel),
      .pinRise  (ctlRise)
   );

   // The shared bus is filtered the same way before it is latched.
   rbc_pin_sync #(
      .W (4)
   ) u_busSync (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .pinIn    (nibble_busIn),
      .pinLevel (busLevel),
      .pinRise  ()
   );

   // Every bus-side input is gated by both chip selects; the crystal
   // base is not, so timekeeping carries on while deselected.
   assign csOk       = ctlLevel[0] & ctlLevel[1];
   assign addrLoad   = csOk & ctlLevel[2];
   assign wrActive   = csOk & ctlLevel[3];
   assign rdActive   = csOk & ctlLevel[4];
   assign haltActive = csOk & ctlLevel[5];
   assign testStep   = csOk & ctlRise[6];

   // Address D under an active write holds the upper stages cleared.
   assign divClear = wrActive && (addrReg == rbc_pkg::ADDR_DIV_RST);

   // Halt suppresses the crystal tick; a test edge still steps once.
   assign countTick = (secTick & ~haltActive) | testStep;

   // Crystal divider.
   rbc_time_base u_timeBase (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .baseRise (ctlRise[7]),
      .clrUpper (divClear),
      .divCount (divCount),
      .secTick  (secTick)
   );

   // The address latch is transparent while the strobe is high.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         addrReg <= 4'h0;
      end
      else if (addrLoad)
      begin
         addrReg <= busLevel;
      end
   end

   // Year modulo four: ten is two modulo four, so tens add 2 when odd.
   assign yearMod4 = 2'(yrUReg[1:0] + {yrTReg[0], 1'b0});

   // Decode the leap select field into the marking remainder.
   always_comb
   begin
      unique case (leapSelReg)
         rbc_pkg::LEAP_SEL_REM0: leapRem = 2'd0;
         rbc_pkg::LEAP_SEL_REM3: leapRem = 2'd3;
         rbc_pkg::LEAP_SEL_REM1: leapRem = 2'd1;
         rbc_pkg::LEAP_SEL_REM2: leapRem = 2'd2;
      endcase
   end

   assign isLeap = (yearMod4 == leapRem);

   // Month length; February follows the leap decision by itself.
   always_comb
   begin
      unique case ({monTReg, monUReg})
         5'h02:   lastDay = isLeap ? rbc_pkg::LAST_DAY_29
                                   : rbc_pkg::LAST_DAY_28;
         5'h04,
         5'h06,
         5'h09,
         5'h11:   lastDay = rbc_pkg::LAST_DAY_30;
         default: lastDay = rbc_pkg::LAST_DAY_31;
      endcase
   end

   assign monthEnd = ({dayTReg, dayUReg} == lastDay);

   // Carry chain between digits.
   assign secWrap = (secUReg == 4'h9) && (secTReg == 3'h5);
   assign minWrap = secWrap && (minUReg == 4'h9) && (minTReg == 3'h5);
   // In 12-hour mode midnight is 11 PM rolling to 12 AM.
   assign dayAdvance = minWrap && (fmt24Reg ?
                       (hrTReg == 2'h2 && hrUReg == 4'h3) :
                       (hrTReg == 2'h1 && hrUReg == 4'h1 && pmReg));

   // Counting cascade: each digit steps when every lower one wraps.
   always_comb
   begin
      secUNext = secUReg;
      secTNext = secTReg;
      minUNext = minUReg;
      minTNext = minTReg;
      hrUNext  = hrUReg;
      hrTNext  = hrTReg;
      pmNext   = pmReg;
      wdayNext = wdayReg;
      dayUNext = dayUReg;
      dayTNext = dayTReg;
      monUNext = monUReg;
      monTNext = monTReg;
      yrUNext  = yrUReg;
      yrTNext  = yrTReg;
      if (countTick)
      begin
         // Seconds: units 0 to 9, tens 0 to 5.
         secUNext = (secUReg == 4'h9) ? 4'h0 : 4'(secUReg + 4'h1);
         if (secUReg == 4'h9)
         begin
            secTNext = (secTReg == 3'h5) ? 3'h0 : 3'(secTReg + 3'h1);
         end
         // Minutes, same ranges.
         if (secWrap)
         begin
            minUNext = (minUReg == 4'h9) ? 4'h0 : 4'(minUReg + 4'h1);
            if (minUReg == 4'h9)
            begin
               minTNext = (minTReg == 3'h5) ? 3'h0 : 3'(minTReg + 3'h1);
            end
         end
         // Hours in the selected format.
         if (minWrap)
         begin
            if (fmt24Reg)
            begin
               if (hrTReg == 2'h2 && hrUReg == 4'h3)
               begin
                  hrTNext = 2'h0;
                  hrUNext = 4'h0;
               end
               else if (hrUReg == 4'h9)
               begin
                  hrTNext = 2'(hrTReg + 2'h1);
                  hrUNext = 4'h0;
               end
               else
               begin
                  hrUNext = 4'(hrUReg + 4'h1);
               end
            end
            else if (hrTReg == 2'h1 && hrUReg == 4'h2)
            begin
               // Twelve o'clock steps on to one o'clock.
               hrTNext = 2'h0;
               hrUNext = 4'h1;
            end
            else if (hrTReg == 2'h1 && hrUReg == 4'h1)
            begin
               // Reaching twelve flips the half of the day.
               hrUNext = 4'h2;
               pmNext  = ~pmReg;
            end
            else if (hrUReg == 4'h9)
            begin
               hrTNext = 2'h1;
               hrUNext = 4'h0;
            end
            else
            begin
               hrUNext = 4'(hrUReg + 4'h1);
            end
         end
         // Day, weekday and the month and year above them.
         if (dayAdvance)
         begin
            wdayNext = (wdayReg == 3'h6) ? 3'h0 : 3'(wdayReg + 3'h1);
            if (monthEnd)
            begin
               dayTNext = 2'h0;
               dayUNext = 4'h1;
               if (monTReg && monUReg == 4'h2)
               begin
                  monTNext = 1'b0;
                  monUNext = 4'h1;
                  yrUNext  = (yrUReg == 4'h9) ? 4'h0 : 4'(yrUReg + 4'h1);
                  if (yrUReg == 4'h9)
                  begin
                     yrTNext = (yrTReg == 4'h9) ? 4'h0 : 4'(yrTReg + 4'h1);
                  end
               end
               else if (monUReg == 4'h9)
               begin
                  monTNext = 1'b1;
                  monUNext = 4'h0;
               end
               else
               begin
                  monUNext = 4'(monUReg + 4'h1);
               end
            end
            else if (dayUReg == 4'h9)
            begin
               dayTNext = 2'(dayTReg + 2'h1);
               dayUNext = 4'h0;
            end
            else
            begin
               dayUNext = 4'(dayUReg + 4'h1);
            end
         end
      end
   end

   // Digit registers. A write wins over the count for the addressed
   // digit and is applied on every cycle the strobe stays high, so a
   // long strobe overrides any count that falls inside it.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         secUReg    <= rbc_pkg::RST_UNITS;
         secTReg    <= 3'h0;
         minUReg    <= rbc_pkg::RST_UNITS;
         minTReg    <= 3'h0;
         hrUReg     <= rbc_pkg::RST_UNITS;
         hrTReg     <= 2'h0;
         fmt24Reg   <= rbc_pkg::RST_FMT24;
         pmReg      <= 1'b0;
         wdayReg    <= 3'h0;
         dayUReg    <= rbc_pkg::RST_ONE;
         dayTReg    <= 2'h0;
         leapSelReg <= rbc_pkg::RST_LEAP;
         monUReg    <= rbc_pkg::RST_ONE;
         monTReg    <= 1'b0;
         yrUReg     <= rbc_pkg::RST_UNITS;
         yrTReg     <= rbc_pkg::RST_UNITS;
      end
      else
      begin
         secUReg <= secUNext;
         secTReg <= secTNext;
         minUReg <= minUNext;
         minTReg <= minTNext;
         hrUReg  <= hrUNext;
         hrTReg  <= hrTNext;
         pmReg   <= pmNext;
         wdayReg <= wdayNext;
         dayUReg <= dayUNext;
         dayTReg <= dayTNext;
         monUReg <= monUNext;
         monTReg <= monTNext;
         yrUReg  <= yrUNext;
         yrTReg  <= yrTNext;
         if (wrActive)
         begin
            // Only implemented bits are kept; the rest are dropped.
            unique case (addrReg)
               rbc_pkg::ADDR_SEC_U: secUReg <= busLevel;
               rbc_pkg::ADDR_SEC_T: secTReg <= busLevel[2:0];
               rbc_pkg::ADDR_MIN_U: minUReg <= busLevel;
               rbc_pkg::ADDR_MIN_T: minTReg <= busLevel[2:0];
               rbc_pkg::ADDR_HR_U:  hrUReg  <= busLevel;
               rbc_pkg::ADDR_HR_T:
               begin
                  hrTReg   <= busLevel[1:0];
                  fmt24Reg <= busLevel[rbc_pkg::FMT24_BIT];
                  // Selecting 24-hour mode forces the morning flag.
                  pmReg    <= busLevel[rbc_pkg::PM_BIT] &
                              ~busLevel[rbc_pkg::FMT24_BIT];
               end
               rbc_pkg::ADDR_WDAY:  wdayReg <= busLevel[2:0];
               rbc_pkg::ADDR_DAY_U: dayUReg <= busLevel;
               rbc_pkg::ADDR_DAY_T:
               begin
                  dayTReg    <= busLevel[1:0];
                  leapSelReg <= busLevel[rbc_pkg::LEAP_MSB:rbc_pkg::LEAP_LSB];
               end
               rbc_pkg::ADDR_MON_U: monUReg <= busLevel;
               rbc_pkg::ADDR_MON_T: monTReg <= busLevel[0];
               rbc_pkg::ADDR_YR_U:  yrUReg  <= busLevel;
               rbc_pkg::ADDR_YR_T:  yrTReg  <= busLevel;
               default:
               begin
                  // Codes D to F store nothing.
               end
            endcase
         end
      end
   end

   // Read selection; absent bits come back as zero.
   always_comb
   begin
      unique case (addrReg)
         rbc_pkg::ADDR_SEC_U:  readData = secUReg;
         rbc_pkg::ADDR_SEC_T:  readData = {1'b0, secTReg};
         rbc_pkg::ADDR_MIN_U:  readData = minUReg;
         rbc_pkg::ADDR_MIN_T:  readData = {1'b0, minTReg};
         rbc_pkg::ADDR_HR_U:   readData = hrUReg;
         rbc_pkg::ADDR_HR_T:   readData = {fmt24Reg, pmReg, hrTReg};
         rbc_pkg::ADDR_WDAY:   readData = {1'b0, wdayReg};
         rbc_pkg::ADDR_DAY_U:  readData = dayUReg;
         rbc_pkg::ADDR_DAY_T:  readData = {leapSelReg, dayTReg};
         rbc_pkg::ADDR_MON_U:  readData = monUReg;
         rbc_pkg::ADDR_MON_T:  readData = {3'h0, monTReg};
         rbc_pkg::ADDR_YR_U:   readData = yrUReg;
         rbc_pkg::ADDR_YR_T:   readData = yrTReg;
         rbc_pkg::ADDR_REF_HI: readData = divCount[14:11];
         rbc_pkg::ADDR_REF_LO: readData = divCount[3:0];
         default:              readData = 4'h0;
      endcase
   end

   // Open-drain data pins: a zero bit is pulled low, a one is released
   // to the pull-up. Nothing is driven unless a selected read is on.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         nibble_busOe <= 4'h0;
      end
      else
      begin
         nibble_busOe <= rdActive ? ~readData : 4'h0;
      end
   end

   // The driven level of an open-drain pin is always low.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         nibble_busOut <= 4'h0;
         busyNOut      <= 1'b0;
      end
      else
      begin
         nibble_busOut <= 4'h0;
         busyNOut      <= 1'b0;
      end
   end

   // Busy (active low, open drain) spans the last eight crystal periods
   // before the second rolls, warning the host that digits are about
   // to change. Halt or a divider reset release it.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busyNOe <= 1'b0;
      end
      else if (divClear)
      begin
         busyNOe <= 1'b0;
      end
      else
      begin
         busyNOe <= (&divCount[14:rbc_pkg::BUSY_LSB]) & ~haltActive;
      end
   end

endmodule : rbc_clock_calendar

/* rtl/rbc_pkg.sv */
// Shared constants for the nibble-bus clock and calendar block.
package rbc_pkg;

   // Digit register addresses on the nibble bus.
   localparam logic [3:0] ADDR_SEC_U   = 4'h0;
   localparam logic [3:0] ADDR_SEC_T   = 4'h1;
   localparam logic [3:0] ADDR_MIN_U   = 4'h2;
   localparam logic [3:0] ADDR_MIN_T   = 4'h3;
   localparam logic [3:0] ADDR_HR_U    = 4'h4;
   localparam logic [3:0] ADDR_HR_T    = 4'h5;
   localparam logic [3:0] ADDR_WDAY    = 4'h6;
   localparam logic [3:0] ADDR_DAY_U   = 4'h7;
   localparam logic [3:0] ADDR_DAY_T   = 4'h8;
   localparam logic [3:0] ADDR_MON_U   = 4'h9;
   localparam logic [3:0] ADDR_MON_T   = 4'ha;
   localparam logic [3:0] ADDR_YR_U    = 4'hb;
   localparam logic [3:0] ADDR_YR_T    = 4'hc;
   // Special codes: divider reset, and the two reference-signal taps.
   localparam logic [3:0] ADDR_DIV_RST = 4'hd;
   localparam logic [3:0] ADDR_REF_HI  = 4'he;
   localparam logic [3:0] ADDR_REF_LO  = 4'hf;

   // Field positions inside the hours-tens and day-tens registers.
   localparam int FMT24_BIT = 3;
   localparam int PM_BIT    = 2;
   localparam int LEAP_LSB  = 2;
   localparam int LEAP_MSB  = 3;

   // Leap-year select codes {bit3,bit2} and the year-mod-4 they mark.
   localparam logic [1:0] LEAP_SEL_REM0 = 2'h0;
   localparam logic [1:0] LEAP_SEL_REM3 = 2'h1;
   localparam logic [1:0] LEAP_SEL_REM1 = 2'h3;
   localparam logic [1:0] LEAP_SEL_REM2 = 2'h2;

   // Month lengths as {day tens, day units} BCD pairs.
   localparam logic [5:0] LAST_DAY_28 = 6'h28;
   localparam logic [5:0] LAST_DAY_29 = 6'h29;
   localparam logic [5:0] LAST_DAY_30 = 6'h30;
   localparam logic [5:0] LAST_DAY_31 = 6'h31;

   // Time base: crystal rate and divider shape.
   localparam int XTAL_HZ     = 32768;
   localparam int DIV_STAGES  = 15;
   localparam int DIV_KEEP    = 10;
   localparam int BUSY_LSB    = 3;

   // Reset values of the calendar: 00:00:00, day 01, month 01, year 00.
   localparam logic       RST_FMT24 = 1'b1;
   localparam logic [3:0] RST_UNITS = 4'h0;
   localparam logic [3:0] RST_ONE   = 4'h1;
   localparam logic [1:0] RST_LEAP  = 2'h0;

endpackage : rbc_pkg

/* rtl/rbc_pin_sync.sv */
// Three-stage synchroniser with agreement filter and rise pulse.
`timescale 1ns/100ps
module rbc_pin_sync #(
   parameter int W = 1
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] pinIn,
   output logic      [W-1:0] pinLevel,
   output logic      [W-1:0] pinRise
);
   logic [W-1:0] stage1Reg;   // First stage, read only by the second.
   logic [W-1:0] stage2Reg;   // Second stage.
   logic [W-1:0] stage3Reg;   // Third stage.

   // Shift chain; the first flop feeds nothing but the second.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stage1Reg <= '0;
         stage2Reg <= '0;
         stage3Reg <= '0;
      end
      else
      begin
         stage1Reg <= pinIn;
         stage2Reg <= stage1Reg;
         stage3Reg <= stage2Reg;
      end
   end

   // A change is accepted only once stages two and three agree.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pinLevel <= '0;
         pinRise  <= '0;
      end
      else
      begin
         for (int i = 0; i < W; i++)
         begin
            pinRise[i] <= (stage2Reg[i] == stage3Reg[i]) && stage3Reg[i] && !pinLevel[i];
            if (stage2Reg[i] == stage3Reg[i])
            begin
               pinLevel[i] <= stage3Reg[i];
            end
         end
      end
   end
endmodule : rbc_pin_sync

/* rtl/rbc_time_base.sv */
// Fifteen-stage crystal divider producing the one-second tick.
`timescale 1ns/100ps
module rbc_time_base (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        baseRise,
   input  wire logic        clrUpper,
   output logic      [14:0] divCount,
   output logic             secTick
);
   // Ones in the stages that survive a partial reset.
   localparam logic [14:0] KEEP_MASK = 15'((1 << rbc_pkg::DIV_KEEP) - 1);

   // Count crystal edges; a partial reset clears only the upper stages,
   // so the sub-second phase below them is not disturbed.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         divCount <= 15'h0000;
         secTick  <= 1'b0;
      end
      else
      begin
         secTick <= 1'b0;
         if (clrUpper)
         begin
            divCount <= divCount & KEEP_MASK;
         end
         else if (baseRise)
         begin
            divCount <= 15'(divCount + 15'h0001);
            // Wrapping all fifteen stages marks one second.
            secTick  <= &divCount;
         end
      end
   end
endmodule : rbc_time_base

/* bench/rbc_clock_calendar_props.sv */
// Pin-level checker for the nibble-bus clock and calendar.
`timescale 1ns/100ps
module rbc_clock_calendar_props (
   input wire logic       ref_clk, rst_n, chip_select_a, chip_select_b,
   input wire logic       addrStrobe, writeStrobe, readStrobe, countHalt,
   input wire logic [3:0] nibble_busIn, nibble_busOut, nibble_busOe,
   input wire logic       busyNOut, busyNOe
);
   // Raw view of the address latch; the [*8] windows absorb the pin synchroniser lag.
   logic       en;
   logic [3:0] addrSeen_reg;
   assign en = chip_select_a && chip_select_b;
   always_ff @(posedge ref_clk or negedge rst_n)
      if (!rst_n) addrSeen_reg <= 4'h0;
      else if (en && addrStrobe) addrSeen_reg <= nibble_busIn;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   property p_csA; !chip_select_a [*8] |-> nibble_busOe == 4'h0; endproperty
   a_csA: assert property (p_csA) else $error("bus pulled with select a low");
   property p_csB; !chip_select_b [*8] |-> nibble_busOe == 4'h0; endproperty
   a_csB: assert property (p_csB) else $error("bus pulled with select b low");
   property p_idle; !readStrobe [*8] |-> nibble_busOe == 4'h0; endproperty
   a_idle: assert property (p_idle) else $error("bus pulled outside a read");
   property p_out; nibble_busOut == 4'h0 && busyNOut == 1'b0; endproperty
   a_out: assert property (p_out) else $error("open-drain level not low");
   property p_halt; (en && countHalt) [*8] |-> !busyNOe; endproperty
   a_halt: assert property (p_halt) else $error("busy while halted");
   property p_div; (en && writeStrobe && addrSeen_reg == 4'hd) [*8] |-> !busyNOe; endproperty
   a_div: assert property (p_div) else $error("busy during divider reset");
   property p_gap; (en && readStrobe && addrSeen_reg == 4'ha) [*8] |->
      nibble_busOe[3:1] == 3'h7; endproperty
   a_gap: assert property (p_gap) else $error("missing bits not read as zero");
   property p_hold; $fell(readStrobe) |-> ##9 (readStrobe || nibble_busOe == 4'h0); endproperty
   a_hold: assert property (p_hold) else $error("bus still pulled after read");
endmodule : rbc_clock_calendar_props
bind rbc_clock_calendar rbc_clock_calendar_props u_rbc_clock_calendar_props (.*);

/* bench/rbc_host_model.sv */
// Host processor model driving the strobes and the open-drain nibble bus.
`timescale 1ns/100ps
module rbc_host_model (
   input  wire logic       ref_clk,
   input  wire logic [3:0] nibble_busOe,
   output logic            chip_select_a, chip_select_b, addrStrobe, writeStrobe,
   output logic            readStrobe, countHalt, testPulse,
   output logic      [3:0] nibble_busIn
);
   logic       hostEn;
   logic [3:0] hostBus;
   // Pull-up wire: released bits read high, either party may pull low.
   assign nibble_busIn = (hostEn ? hostBus : 4'hf) & ~nibble_busOe;
   // Selected and halted from time zero, so only the test pulse steps time
   // and every read is valid whatever the busy pin shows.
   initial {chip_select_a, chip_select_b, countHalt, addrStrobe, writeStrobe,
      readStrobe, testPulse, hostEn, hostBus} = 12'he00;
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : step
   // Holds each level well past the device's pin synchroniser.
   task automatic latch(input logic [3:0] a);
      hostEn <= 1'b1;
      hostBus <= a;
      addrStrobe <= 1'b1;
      step(7);
      addrStrobe <= 1'b0;
      step(7);
   endtask : latch
   task automatic wr(input logic [3:0] a, input logic [3:0] d);
      latch(a);
      hostBus <= d;
      writeStrobe <= 1'b1;
      step(8);
      writeStrobe <= 1'b0;
      step(7);
      hostEn <= 1'b0;
      step(1);
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [3:0] d);
      latch(a);
      hostEn <= 1'b0;
      readStrobe <= 1'b1;
      step(8);
      d = nibble_busIn;
      readStrobe <= 1'b0;
      step(8);
   endtask : rd
   // Chip selects change only here, between transfers.
   task automatic sel(input logic a, input logic b);
      chip_select_a <= a;
      chip_select_b <= b;
   endtask : sel
   task automatic tick;
      testPulse <= 1'b1;
      step(8);
      testPulse <= 1'b0;
      step(8);
   endtask : tick
endmodule : rbc_host_model

/* bench/testbench.sv */
// Self-checking bench of the clock and calendar driven through the host model.
`timescale 1ns/100ps
module testbench;
   logic ref_clk = 1'b0, rst_n = 1'b0, timeBaseIn = 1'b0;
   wire  chip_select_a, chip_select_b, addrStrobe, writeStrobe, readStrobe;
   wire  countHalt, testPulse;
   wire  [3:0] nibble_busIn, nibble_busOe;
   logic [3:0] rdv;
   int   n_errors = 0, samples_checked = 0;
   // Rows of {address, written nibble, nibble read back}.
   logic [11:0] rows [13] = '{12'h099, 12'h1f7, 12'h255, 12'h355, 12'h433, 12'h5c8,
      12'h6f7, 12'h788, 12'h8ff, 12'h922, 12'haf1, 12'hb77, 12'hc99};
   always #2 ref_clk = ~ref_clk;
   always #40 timeBaseIn = ~timeBaseIn;
   rbc_clock_calendar u_rbc_clock_calendar (.ref_clk, .rst_n, .chip_select_a,
      .chip_select_b, .addrStrobe, .writeStrobe, .readStrobe, .countHalt, .testPulse,
      .timeBaseIn, .nibble_busIn, .nibble_busOut(), .nibble_busOe, .busyNOut(), .busyNOe());
   rbc_host_model u_host (.ref_clk, .nibble_busOe, .chip_select_a, .chip_select_b,
      .addrStrobe, .writeStrobe, .readStrobe, .countHalt, .testPulse, .nibble_busIn);
   task automatic check(input logic [3:0] seen, input logic [3:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test;
      $display("checks %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   // Sets xx:59:59 on February 28, steps one second and reads day, hours tens, weekday.
   // Packing: {year units, day tens, hours tens, hours units, day, hours tens, weekday}.
   task automatic cal(input logic [27:0] c);
      logic [3:0] v [13];
      v = '{4'h9, 4'h5, 4'h9, 4'h5, c[15:12], c[19:16], 4'h6, 4'h8, c[23:20], 4'h2,
         4'h0, c[27:24], 4'h2};
      for (int i = 0; i < 13; i++) u_host.wr(i[3:0], v[i]);
      u_host.tick();
      u_host.rd(4'h7, rdv);
      check(rdv, c[11:8]);
      u_host.rd(4'h5, rdv);
      check(rdv, c[7:4]);
      u_host.rd(4'h6, rdv);
      check(rdv, c[3:0]);
   endtask : cal
   initial
   begin
      repeat (100000) @(posedge ref_clk);
      n_errors++;
      finish_test();
   end
   initial
   begin
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 13; i++)
      begin
         u_host.wr(rows[i][11:8], rows[i][7:4]);
         u_host.rd(rows[i][11:8], rdv);
         check(rdv, rows[i][3:0]);
      end
      $display("register table done");
      cal(28'h42a3980);
      cal(28'h36a3980);
      cal(28'h1ea3980);
      cal(28'h52a3180);
      cal(28'h4211856);
      cal(28'h4251910);
      $display("calendar steps done");
      u_host.sel(1'b1, 1'b0);
      u_host.wr(4'h0, 4'h3);
      u_host.sel(1'b0, 1'b1);
      u_host.rd(4'h0, rdv);
      check(rdv, 4'hf);
      u_host.sel(1'b1, 1'b1);
      u_host.rd(4'h0, rdv);
      check(rdv, 4'h0);
      u_host.rd(4'ha, rdv);
      check(rdv, 4'h0);
      // Let the divider climb into its upper stages so that the clear shows.
      repeat (46000) @(posedge ref_clk);
      u_host.rd(4'he, rdv);
      check(rdv, 4'h1);
      u_host.wr(4'hd, 4'h0);
      u_host.rd(4'he, rdv);
      check(rdv, 4'h0);
      $display("select and divider tests done");
      rst_n <= 1'b0;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      u_host.rd(4'h5, rdv);
      check(rdv, 4'h8);
      $display("reset test done");
      finish_test();
   end
endmodule : testbench
